//--- hdl/hscp_pkg.sv
package hscp_pkg;
  // Serial opcodes and byte addresses of the port registers
  localparam logic [7:0] OP_WRITE = 8'h02;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] ADDR_CTRL_MID = 8'h01;
  localparam logic [7:0] ADDR_CMD_HI = 8'h03;
  localparam logic [7:0] ADDR_CMD_LO = 8'h05;
  localparam logic [7:0] ADDR_DAT1_HI = 8'h06;
  localparam logic [7:0] ADDR_DAT2_HI = 8'h09;
  localparam int REG_BYTES = 12;
  localparam int BUSY_BIT = 0;
  localparam logic [7:0] REG_BYTE_RST = 8'h00;
  // Command codes
  localparam logic [23:0] CMD_WR_FREG = 24'h00_0001;
  localparam logic [23:0] CMD_RD_FREG = 24'h00_0002;
  // Timing
  localparam int CLK_NS = 8;
  localparam int PULSE_NS = 1000;
  localparam int PULSE_CYC = PULSE_NS / CLK_NS;
  localparam int PROC_NS = 2000;
  localparam int PROC_CYC = (PROC_NS + CLK_NS - 1) / CLK_NS;
  localparam int SCLK_MAX_KHZ = 4096;
  localparam int SCLK_HALF_CYC =
    (1000000000 + 2 * SCLK_MAX_KHZ * 1000 * CLK_NS - 1) /
    (2 * SCLK_MAX_KHZ * 1000 * CLK_NS);
  // Host APB map
  localparam logic [7:0] APB_CTRL = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_TX0 = 8'h08;
  localparam logic [7:0] APB_TX1 = 8'h0C;
  localparam logic [7:0] APB_TX2 = 8'h10;
  localparam logic [7:0] APB_RX0 = 8'h14;
  localparam logic [7:0] APB_RX1 = 8'h18;
  localparam logic [7:0] APB_RX2 = 8'h1C;
  localparam int STAT_XFER_BIT = 0;
  localparam int STAT_READY_BIT = 1;
  localparam logic [3:0] MAX_LEN = 4'hC;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00,
    HS_LEAD = 2'b01,
    HS_SHIFT = 2'b10,
    HS_TRAIL = 2'b11
  } hscp_state_t;
endpackage : hscp_pkg

//--- hdl/hscp_if.sv
`timescale 1ns/1ps
interface hscp_if;
  logic port_select_n;
  logic port_serial_clock;
  logic mosi;
  logic miso_o;
  logic miso_oe_n;
  logic miso;
  logic ready_pulse_n;
  // Open drain with pull-up: released line reads high
  assign miso = miso_oe_n ? 1'b1 : miso_o;
  modport dev (
    input port_select_n, port_serial_clock, mosi,
    output miso_o, miso_oe_n, ready_pulse_n
  );
  modport host (
    output port_select_n, port_serial_clock, mosi,
    input miso, ready_pulse_n
  );
endinterface : hscp_if

//--- hdl/hscp_sync.sv
`timescale 1ns/1ps
module hscp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_ff;
  logic [W-1:0] q_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= RST;
      q_ff <= RST;
    end else begin
      meta_ff <= d;
      q_ff <= meta_ff;
    end
  end

  assign q = q_ff;
endmodule : hscp_sync

//--- hdl/hscp_device.sv
`timescale 1ns/1ps
// Behaviour
// - Select low frames; high ignores traffic
// - Host keeps serial clock at most 4.096 MHz
// - Input changes falling, sampled on rising
// - Output open drain, changes on falling
// - Ready pulse low about one microsecond
// - Ready pulse after command processing ends
// - Opcode then address; 02 writes, 03 reads
// - Data bytes at consecutive addresses
// - Registers as high, mid, low bytes
// - One write: command plus two words
// - Host writes five, eight, eleven bytes
// - Read three or five bytes, leading don't-care
// - Host waits for ready between transactions
// - Busy flag in control mid byte
// - Control mid byte readable at any time
// - Command 1 writes internal filter register
// - Host toggles select, drives clock and data
// - Boot pin low after reset enables port
// - Command 2 copies filter register to data
module hscp_device #(
  parameter int PROC_CYC = hscp_pkg::PROC_CYC,
  parameter int FREG_AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  hscp_if.dev link,
  input wire logic boot_pin,
  output logic host_boot,
  output logic command_busy_flag,
  output logic filt_wr_stb,
  output logic [FREG_AW-1:0] filt_addr,
  output logic [23:0] filt_wdata,
  output logic cmd_stb,
  output logic [23:0] cmd_code
);
  logic boot_s;
  logic sel_n_s;
  logic sclk_s;
  logic mosi_s;
  logic sclk_d_ff;
  logic [1:0] boot_cnt_ff;
  logic host_boot_ff;
  logic [2:0] bit_cnt_ff;
  logic [1:0] byte_idx_ff;
  logic [7:0] rx_ff;
  logic [7:0] op_ff;
  logic [7:0] ptr_ff;
  logic [7:0] tx_ff;
  logic [7:0] regs_ff [hscp_pkg::REG_BYTES];
  logic [23:0] freg_mem [2**FREG_AW];
  logic busy_ff;
  logic cmd_pend_ff;
  logic [15:0] proc_cnt_ff;
  logic [15:0] pulse_cnt_ff;
  logic ready_n_ff;
  logic filt_wr_ff;
  logic [FREG_AW-1:0] filt_addr_ff;
  logic [23:0] filt_wdata_ff;
  logic cmd_stb_ff;
  logic [23:0] cmd_code_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detect
  hscp_sync #(
    .W(4),
    .RST(4'b0100)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({boot_pin, link.port_select_n, link.port_serial_clock, link.mosi}),
    .q({boot_s, sel_n_s, sclk_s, mosi_s})
  );

  wire active = host_boot_ff & ~sel_n_s;
  wire sclk_rise = sclk_s & ~sclk_d_ff;
  wire sclk_fall = ~sclk_s & sclk_d_ff;
  wire [7:0] nxt_rx = {rx_ff[6:0], mosi_s};
  wire byte_done = active & sclk_rise & (bit_cnt_ff == 3'd7);
  wire data_phase = (byte_idx_ff == 2'd2);
  wire is_read = (op_ff == hscp_pkg::OP_READ);
  wire ptr_ok = (ptr_ff < 8'(hscp_pkg::REG_BYTES));
  wire reg_wr = byte_done & data_phase & ptr_ok &
                (op_ff == hscp_pkg::OP_WRITE);
  wire cmd_start = reg_wr & (ptr_ff == hscp_pkg::ADDR_CMD_LO) & ~busy_ff;
  wire proc_end = busy_ff & ~cmd_pend_ff & (proc_cnt_ff == 16'd1);
  wire [23:0] cmd_word = {regs_ff[3], regs_ff[4], regs_ff[5]};
  wire [23:0] dat1_word = {regs_ff[6], regs_ff[7], regs_ff[8]};
  wire [23:0] dat2_word = {regs_ff[9], regs_ff[10], regs_ff[11]};
  wire [FREG_AW-1:0] freg_sel = dat1_word[FREG_AW-1:0];
  wire [23:0] freg_rd = freg_mem[freg_sel];
  wire do_wr_freg = proc_end & (cmd_word == hscp_pkg::CMD_WR_FREG);
  wire do_rd_freg = proc_end & (cmd_word == hscp_pkg::CMD_RD_FREG);
  // Busy bit read live, never stale from storage
  wire [7:0] ctrl_mid = {regs_ff[1][7:1], busy_ff};
  wire [7:0] rd_byte = !ptr_ok ? 8'h00 :
                       (ptr_ff == hscp_pkg::ADDR_CTRL_MID) ? ctrl_mid :
                       regs_ff[ptr_ff[3:0]];

  ////////////////////////////////////////////////////////////////////////////
  // Boot source capture
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_cnt_ff <= 2'd0;
      host_boot_ff <= 1'b0;
    end else if (boot_cnt_ff != 2'd3) begin
      boot_cnt_ff <= boot_cnt_ff + 2'd1;
      if (boot_cnt_ff == 2'd2) begin
        host_boot_ff <= ~boot_s;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial framing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_d_ff <= 1'b0;
      bit_cnt_ff <= 3'd0;
      byte_idx_ff <= 2'd0;
      rx_ff <= 8'h00;
      op_ff <= 8'h00;
      ptr_ff <= 8'h00;
      tx_ff <= 8'hFF;
    end else begin
      sclk_d_ff <= sclk_s;
      if (!active) begin
        bit_cnt_ff <= 3'd0;
        byte_idx_ff <= 2'd0;
        tx_ff <= 8'hFF;
      end else if (sclk_rise) begin
        rx_ff <= nxt_rx;
        bit_cnt_ff <= bit_cnt_ff + 3'd1;
        if (byte_done) begin
          unique case (byte_idx_ff)
            2'd0: op_ff <= nxt_rx;
            2'd1: ptr_ff <= nxt_rx;
            default: ptr_ff <= (ptr_ff == 8'hFF) ? ptr_ff : ptr_ff + 8'd1;
          endcase
          byte_idx_ff <= data_phase ? byte_idx_ff : byte_idx_ff + 2'd1;
        end
      end else if (sclk_fall) begin
        if (bit_cnt_ff == 3'd0 && data_phase && is_read) begin
          tx_ff <= rd_byte;
        end else begin
          tx_ff <= {tx_ff[6:0], 1'b1};
        end
      end
    end
  end

  assign link.miso_o = 1'b0;
  assign link.miso_oe_n = tx_ff[7];

  ////////////////////////////////////////////////////////////////////////////
  // Port registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < hscp_pkg::REG_BYTES; i++) begin
        regs_ff[i] <= hscp_pkg::REG_BYTE_RST;
      end
    end else if (do_rd_freg) begin
      regs_ff[6] <= freg_rd[23:16];
      regs_ff[7] <= freg_rd[15:8];
      regs_ff[8] <= freg_rd[7:0];
    end else if (reg_wr) begin
      regs_ff[ptr_ff[3:0]] <= nxt_rx;
    end
  end

  // Filter registers hold no reset value, like the array they model
  always_ff @(posedge pclk) begin
    if (do_wr_freg) begin
      freg_mem[freg_sel] <= dat2_word;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command processing and ready pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_ff <= 1'b0;
      cmd_pend_ff <= 1'b0;
      proc_cnt_ff <= 16'd0;
      pulse_cnt_ff <= 16'd0;
      ready_n_ff <= 1'b1;
      filt_wr_ff <= 1'b0;
      filt_addr_ff <= '0;
      filt_wdata_ff <= 24'h00_0000;
      cmd_stb_ff <= 1'b0;
      cmd_code_ff <= 24'h00_0000;
    end else begin
      filt_wr_ff <= do_wr_freg;
      cmd_stb_ff <= proc_end & ~do_wr_freg & ~do_rd_freg;
      if (proc_end) begin
        filt_addr_ff <= freg_sel;
        filt_wdata_ff <= dat2_word;
        cmd_code_ff <= cmd_word;
      end
      // Busy while processing
      // Count held until frame ends: data words follow the command
      if (cmd_start) begin
        busy_ff <= 1'b1;
        cmd_pend_ff <= 1'b1;
        proc_cnt_ff <= 16'(PROC_CYC);
      end else if (cmd_pend_ff) begin
        cmd_pend_ff <= active;
      end else if (busy_ff) begin
        proc_cnt_ff <= proc_cnt_ff - 16'd1;
        busy_ff <= ~proc_end;
      end
      if (proc_end) begin
        pulse_cnt_ff <= 16'(hscp_pkg::PULSE_CYC);
        ready_n_ff <= 1'b0;
      end else if (pulse_cnt_ff != 16'd0) begin
        pulse_cnt_ff <= pulse_cnt_ff - 16'd1;
        ready_n_ff <= (pulse_cnt_ff == 16'd1);
      end
    end
  end

  assign link.ready_pulse_n = ready_n_ff;
  assign host_boot = host_boot_ff;
  assign command_busy_flag = busy_ff;
  assign filt_wr_stb = filt_wr_ff;
  assign filt_addr = filt_addr_ff;
  assign filt_wdata = filt_wdata_ff;
  assign cmd_stb = cmd_stb_ff;
  assign cmd_code = cmd_code_ff;
endmodule : hscp_device

//--- hdl/hscp_host.sv
`timescale 1ns/1ps
module hscp_host #(
  parameter int HALF_CYC = hscp_pkg::SCLK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  hscp_if.host link
);
  logic miso_s;
  logic rdy_n_s;
  logic rdy_d_ff;
  hscp_pkg::hscp_state_t st_ff;
  logic phase_ff;
  logic [15:0] div_ff;
  logic [6:0] bits_ff;
  logic [3:0] len_ff;
  logic [31:0] tx_w_ff [3];
  logic [95:0] tx_sh_ff;
  logic [95:0] rx_ff;
  logic ready_seen_ff;
  logic sel_n_ff;
  logic sclk_ff;
  logic mosi_ff;
  logic [31:0] prdata_ff;

  hscp_sync #(
    .W(2),
    .RST(2'b11)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d({link.miso, link.ready_pulse_n}),
    .q({miso_s, rdy_n_s})
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire apb_wr = psel & penable & pwrite;
  wire idle = (st_ff == hscp_pkg::HS_IDLE);
  wire [3:0] wr_len = pwdata[3:0];
  wire start = apb_wr & (paddr == hscp_pkg::APB_CTRL) & idle &
               (wr_len != 4'h0) & (wr_len <= hscp_pkg::MAX_LEN);
  wire clr_ready = apb_wr & (paddr == hscp_pkg::APB_STATUS) &
                   pwdata[hscp_pkg::STAT_READY_BIT];
  wire ready_evt = ~rdy_n_s & rdy_d_ff;
  wire tick = (div_ff == 16'd0);
  wire [31:0] status = {30'd0, ready_seen_ff, ~idle};
  wire [31:0] rd_mux =
    (paddr == hscp_pkg::APB_CTRL) ? {28'd0, len_ff} :
    (paddr == hscp_pkg::APB_STATUS) ? status :
    (paddr == hscp_pkg::APB_TX0) ? tx_w_ff[0] :
    (paddr == hscp_pkg::APB_TX1) ? tx_w_ff[1] :
    (paddr == hscp_pkg::APB_TX2) ? tx_w_ff[2] :
    (paddr == hscp_pkg::APB_RX0) ? rx_ff[95:64] :
    (paddr == hscp_pkg::APB_RX1) ? rx_ff[63:32] :
    (paddr == hscp_pkg::APB_RX2) ? rx_ff[31:0] : hscp_pkg::WORD_RST;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= hscp_pkg::WORD_RST;
      len_ff <= 4'h0;
      ready_seen_ff <= 1'b0;
      rdy_d_ff <= 1'b1;
      for (int i = 0; i < 3; i++) begin
        tx_w_ff[i] <= hscp_pkg::WORD_RST;
      end
    end else begin
      rdy_d_ff <= rdy_n_s;
      if (psel && !penable) begin
        prdata_ff <= rd_mux;
      end
      if (start) begin
        len_ff <= wr_len;
      end
      if (ready_evt) begin
        ready_seen_ff <= 1'b1;
      end else if (clr_ready) begin
        ready_seen_ff <= 1'b0;
      end
      if (apb_wr && paddr == hscp_pkg::APB_TX0) tx_w_ff[0] <= pwdata;
      if (apb_wr && paddr == hscp_pkg::APB_TX1) tx_w_ff[1] <= pwdata;
      if (apb_wr && paddr == hscp_pkg::APB_TX2) tx_w_ff[2] <= pwdata;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Serial master; clock divided from pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= hscp_pkg::HS_IDLE;
      phase_ff <= 1'b0;
      div_ff <= 16'd0;
      bits_ff <= 7'd0;
      tx_sh_ff <= 96'd0;
      rx_ff <= 96'd0;
      sel_n_ff <= 1'b1;
      sclk_ff <= 1'b0;
      mosi_ff <= 1'b0;
    end else begin
      div_ff <= tick ? 16'(HALF_CYC - 1) : div_ff - 16'd1;
      unique case (st_ff)
        hscp_pkg::HS_IDLE: begin
          div_ff <= 16'(HALF_CYC - 1);
          if (start) begin
            st_ff <= hscp_pkg::HS_LEAD;
            sel_n_ff <= 1'b0;
            tx_sh_ff <= {tx_w_ff[0], tx_w_ff[1], tx_w_ff[2]};
            mosi_ff <= tx_w_ff[0][31];
            bits_ff <= {wr_len, 3'd0};
            rx_ff <= 96'd0;
          end
        end
        hscp_pkg::HS_LEAD: begin
          if (tick) begin
            st_ff <= hscp_pkg::HS_SHIFT;
            phase_ff <= 1'b0;
          end
        end
        hscp_pkg::HS_SHIFT: begin
          if (tick && !phase_ff) begin
            sclk_ff <= 1'b1;
            phase_ff <= 1'b1;
            rx_ff <= {rx_ff[94:0], miso_s};
          end else if (tick) begin
            sclk_ff <= 1'b0;
            phase_ff <= 1'b0;
            bits_ff <= bits_ff - 7'd1;
            tx_sh_ff <= {tx_sh_ff[94:0], 1'b0};
            mosi_ff <= tx_sh_ff[94];
            if (bits_ff == 7'd1) begin
              st_ff <= hscp_pkg::HS_TRAIL;
            end
          end
        end
        hscp_pkg::HS_TRAIL: begin
          if (tick) begin
            st_ff <= hscp_pkg::HS_IDLE;
            sel_n_ff <= 1'b1;
            mosi_ff <= 1'b0;
          end
        end
      endcase
    end
  end

  assign link.port_select_n = sel_n_ff;
  assign link.port_serial_clock = sclk_ff;
  assign link.mosi = mosi_ff;
endmodule : hscp_host

//--- sim/hscp_properties.sv
`timescale 1ns/1ps
module hscp_properties #(
  parameter int HALF_CYC = hscp_pkg::SCLK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic port_select_n,
  input wire logic port_serial_clock,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe_n,
  input wire logic miso,
  input wire logic ready_pulse_n
);
  logic [15:0] low_cnt_ff;
  logic [15:0] hi_cnt_ff;
  logic [15:0] bits_ff;
  logic sclk_q_ff;
  // Run lengths: cycles low on the pulse, cycles high on the clock
  wire [15:0] nxt_low_cnt = ready_pulse_n ? 16'h0000 : low_cnt_ff + 16'h0001;
  wire [15:0] nxt_hi_cnt =
    port_serial_clock ? hi_cnt_ff + 16'h0001 : 16'h0000;
  wire sclk_rise = port_serial_clock & ~sclk_q_ff;
  wire [15:0] nxt_bits =
    port_select_n ? 16'h0000 : bits_ff + {15'h0000, sclk_rise};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_cnt_ff <= 16'h0000;
      hi_cnt_ff <= 16'h0000;
      bits_ff <= 16'h0000;
      sclk_q_ff <= 1'b0;
    end else begin
      low_cnt_ff <= nxt_low_cnt;
      hi_cnt_ff <= nxt_hi_cnt;
      bits_ff <= nxt_bits;
      sclk_q_ff <= port_serial_clock;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////////
  a_sel_quiet: assert property (
    port_select_n |-> !port_serial_clock) else $error("clock outside frame");
  a_sel_lead: assert property (
    $fell(port_select_n) |-> !port_serial_clock [*8])
    else $error("clock too soon after select");
  a_sclk_half: assert property (
    $fell(port_serial_clock) |-> hi_cnt_ff == HALF_CYC)
    else $error("clock high time wrong");
  a_mosi_on_fall: assert property (
    !port_select_n && $changed(mosi) |-> !port_serial_clock)
    else $error("data in changed while clock high");
  a_miso_on_fall: assert property (
    $changed(miso_oe_n) |-> !port_serial_clock)
    else $error("data out changed while clock high");
  a_miso_low_only: assert property (
    miso_o == 1'b0 && (!miso_oe_n || miso))
    else $error("data out not open drain");
  a_release_idle: assert property (
    port_select_n [*8] |-> miso_oe_n) else $error("data out held unselected");
  a_pulse_width: assert property (
    $rose(ready_pulse_n) |-> low_cnt_ff == hscp_pkg::PULSE_CYC)
    else $error("ready pulse width wrong");
  a_pulse_single: assert property (
    $rose(ready_pulse_n) |-> ready_pulse_n [*8])
    else $error("ready pulse repeated");
  a_byte_frames: assert property (
    $rose(port_select_n) |-> bits_ff[2:0] == 3'b000 && bits_ff != 16'h0000)
    else $error("frame not whole bytes");
endmodule : hscp_properties

//--- sim/test_host_serial_config_port.sv
`timescale 1ns/1ps
module test_host_serial_config_port;
  localparam int LIMIT = 60000;
  // Long enough that a status read can land inside the busy time
  localparam int PROC = 2000;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic boot_pin = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic host_boot;
  logic command_busy_flag;
  logic filt_wr_stb;
  logic cmd_stb;
  logic [7:0] filt_addr;
  logic [23:0] filt_wdata;
  logic [23:0] cmd_code;
  logic [7:0] got_addr = 8'h00;
  logic [23:0] got_wdata = 24'h00_0000;
  logic [23:0] got_cmd = 24'h00_0000;
  logic [31:0] rd;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  always #4 pclk = ~pclk;
  hscp_if hscp_if_inst ();
  hscp_device #(.PROC_CYC(PROC), .FREG_AW(8)) hscp_device_inst (
    .pclk(pclk), .presetn(presetn), .link(hscp_if_inst), .boot_pin(boot_pin),
    .host_boot(host_boot), .command_busy_flag(command_busy_flag),
    .filt_wr_stb(filt_wr_stb), .filt_addr(filt_addr),
    .filt_wdata(filt_wdata), .cmd_stb(cmd_stb), .cmd_code(cmd_code));
  hscp_host #(.HALF_CYC(hscp_pkg::SCLK_HALF_CYC)) hscp_host_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(), .link(hscp_if_inst));
  hscp_properties #(.HALF_CYC(hscp_pkg::SCLK_HALF_CYC)) hscp_properties_inst (
    .pclk(pclk), .presetn(presetn),
    .port_select_n(hscp_if_inst.port_select_n),
    .port_serial_clock(hscp_if_inst.port_serial_clock),
    .mosi(hscp_if_inst.mosi), .miso_o(hscp_if_inst.miso_o),
    .miso_oe_n(hscp_if_inst.miso_oe_n), .miso(hscp_if_inst.miso),
    .ready_pulse_n(hscp_if_inst.ready_pulse_n));
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    if (filt_wr_stb === 1'b1) begin
      got_addr <= filt_addr;
      got_wdata <= filt_wdata;
    end
    if (cmd_stb === 1'b1) begin
      got_cmd <= cmd_code;
    end
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      err_count++;
      test_done();
    end
  end
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done
  task chk(input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t exp %h got %h", $time, exp, got);
    end
  endtask : chk
  // One transfer, entered just after a rising edge; idles one cycle after
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task xfer(input logic [3:0] n, input logic [31:0] t0, t1, t2);
    apb(1'b1, hscp_pkg::APB_TX0, t0);
    apb(1'b1, hscp_pkg::APB_TX1, t1);
    apb(1'b1, hscp_pkg::APB_TX2, t2);
    apb(1'b1, hscp_pkg::APB_CTRL, {28'h000_0000, n});
    do apb(1'b0, hscp_pkg::APB_STATUS, 32'h0000_0000); while (rd[0] !== 1'b0);
    apb(1'b0, hscp_pkg::APB_RX2, 32'h0000_0000);
  endtask : xfer
  task wait_ready;
    do apb(1'b0, hscp_pkg::APB_STATUS, 32'h0000_0000); while (rd[1] !== 1'b1);
    apb(1'b1, hscp_pkg::APB_STATUS, 32'h0000_0002);
    apb(1'b0, hscp_pkg::APB_STATUS, 32'h0000_0000);
    chk(32'h0000_0000, {31'h0000_0000, rd[1]});
  endtask : wait_ready
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    chk(32'h0000_0001, {31'h0000_0000, host_boot});
    apb(1'b0, hscp_pkg::APB_STATUS, 32'h0000_0000);
    chk(32'h0000_0000, rd);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk(32'h0000_0000, rd);
    $display("reset test done");
    // Plain command code, then a status read straight after it
    xfer(4'h5, 32'h0203_0000, 32'h0900_0000, 32'h0000_0000);
    xfer(4'h3, 32'h0301_0000, 32'h0000_0000, 32'h0000_0000);
    chk(32'h0000_0001, {24'h00_0000, rd[7:0]});
    do xfer(4'h3, 32'h0301_0000, 32'h0, 32'h0); while (rd[7:0] !== 8'h00);
    chk(32'h0000_0009, {8'h00, got_cmd});
    wait_ready();
    $display("busy test done");
    // Eleven byte write: command, register number, value
    xfer(4'hB, 32'h0203_0000, 32'h0100_005A, 32'h1234_5600);
    wait_ready();
    chk(32'h0000_0000, {31'h0000_0000, command_busy_flag});
    chk(32'h0000_005A, {24'h00_0000, got_addr});
    chk(32'h0012_3456, {8'h00, got_wdata});
    $display("write test done");
    // Read back through the first data register
    xfer(4'h5, 32'h0203_0000, 32'h0200_0000, 32'h0000_0000);
    wait_ready();
    xfer(4'h5, 32'h0306_0000, 32'h0000_0000, 32'h0000_0000);
    chk(32'h0012_3456, {8'h00, rd[23:0]});
    $display("read test done");
    // Boot pin high: port must stay deaf after a fresh reset
    boot_pin <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (12) @(posedge pclk);
    chk(32'h0000_0000, {31'h0000_0000, host_boot});
    xfer(4'h5, 32'h0203_0000, 32'h0900_0000, 32'h0000_0000);
    chk(32'h0000_0000, {31'h0000_0000, command_busy_flag});
    $display("boot test done");
    test_done();
  end
endmodule : test_host_serial_config_port
